// ===== verilog/iobdp_top.sv
`timescale 1ns/10ps
// Data path between the expansion bus and the peripheral logic.
// Bus data lines are open drain style: oe high pulls/drives the line.
module iobdp_top (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic [4:0]           code_switch_array,
  input  wire logic [4:0]           upper_select_bits,
  input  wire logic                 lowest_select_bit,
  input  wire logic                 interrupt_acknowledge,
  input  wire logic                 int_priority_win,
  input  wire logic                 code_lsb_jumper,
  input  wire logic [15:0]          bus_data_in,
  output logic      [15:0]          bus_data_out,
  output logic      [15:0]          bus_data_oe,
  input  wire logic                 gate_in_reg,
  input  wire logic                 gate_direct,
  input  wire logic [15:0]          direct_data,
  input  wire logic                 out_load_from_bus,
  input  wire iobdp_pkg::iobdp_ctl_s in_ctl,
  input  wire iobdp_pkg::iobdp_ctl_s out_ctl,
  output logic      [15:0]          in_word,
  output logic      [15:0]          out_word,
  output logic                      in_ser_out,
  output logic                      out_ser_out,
  output logic                      primary_select,
  output logic                      secondary_select
);
  logic [15:0] in_word_reg;
  logic [15:0] out_word_reg;
  logic [15:0] bus_out_reg;
  logic [15:0] bus_oe_reg;
  logic        pri_reg;
  logic        sec_reg;
  logic [4:0]  dev_code;

  // Next register value for one control word
  function automatic logic [15:0] word_next(input logic [15:0] cur,
                                            input iobdp_pkg::iobdp_ctl_s c);
    case (c.op)
      iobdp_pkg::IOBDP_LOAD:  word_next = c.par_in;
      iobdp_pkg::IOBDP_LEFT:  word_next = {c.ser_in, cur[15:1]};
      iobdp_pkg::IOBDP_RIGHT: word_next = {cur[14:0], c.ser_in};
      default:                word_next = cur;
    endcase
  endfunction

  // Board select compare against the switch code
  function automatic logic code_match(input logic [4:0] sel,
                                      input logic [4:0] code);
    code_match = (sel == code);
  endfunction

  // Switch open reads high, so the pin level is the code bit
  assign dev_code = code_switch_array;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      in_word_reg <= iobdp_pkg::WORD_RST;
    end else begin
      in_word_reg <= word_next(in_word_reg, in_ctl);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_word_reg <= iobdp_pkg::WORD_RST;
    end else if (out_load_from_bus) begin
      out_word_reg <= bus_data_in;
    end else begin
      out_word_reg <= word_next(out_word_reg, out_ctl);
    end
  end

  // Bus drive: acknowledge code has priority over data gates
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_out_reg <= iobdp_pkg::BUS_IDLE;
      bus_oe_reg  <= iobdp_pkg::BUS_IDLE;
    end else if (interrupt_acknowledge && int_priority_win) begin
      bus_out_reg <= {10'h000, dev_code, code_lsb_jumper};
      bus_oe_reg  <= iobdp_pkg::OE_CODE;
    end else if (gate_in_reg) begin
      bus_out_reg <= word_next(in_word_reg, in_ctl);
      bus_oe_reg  <= iobdp_pkg::OE_ALL;
    end else if (gate_direct) begin
      bus_out_reg <= direct_data;
      bus_oe_reg  <= iobdp_pkg::OE_ALL;
    end else begin
      bus_out_reg <= iobdp_pkg::BUS_IDLE;
      bus_oe_reg  <= iobdp_pkg::BUS_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pri_reg <= 1'b0;
      sec_reg <= 1'b0;
    end else begin
      pri_reg <= code_match(upper_select_bits, dev_code) && !lowest_select_bit;
      sec_reg <= code_match(upper_select_bits, dev_code) && lowest_select_bit;
    end
  end

  assign in_word          = in_word_reg;
  assign out_word         = out_word_reg;
  assign in_ser_out       = in_word_reg[0];
  assign out_ser_out      = out_word_reg[0];
  assign bus_data_out     = bus_out_reg;
  assign bus_data_oe      = bus_oe_reg;
  assign primary_select   = pri_reg;
  assign secondary_select = sec_reg;

  property p_sel_excl;
    @(posedge clk_sys) disable iff (rst) !(primary_select && secondary_select);
  endproperty
  a_sel_excl: assert property (p_sel_excl) else $error("both selects");

  property p_pri;
    @(posedge clk_sys) disable iff (rst)
      (upper_select_bits == code_switch_array && !lowest_select_bit) |=> primary_select;
  endproperty
  a_pri: assert property (p_pri) else $error("primary select missed");

  property p_sec;
    @(posedge clk_sys) disable iff (rst)
      (upper_select_bits == code_switch_array && lowest_select_bit) |=> secondary_select;
  endproperty
  a_sec: assert property (p_sec) else $error("secondary select missed");

  property p_interrupt_acknowledge;
    @(posedge clk_sys) disable iff (rst) (interrupt_acknowledge && int_priority_win)
      |=> bus_data_oe == 16'h003F && bus_data_out[5:1] == $past(code_switch_array);
  endproperty
  a_interrupt_acknowledge: assert property (p_interrupt_acknowledge) else $error("device code not driven");

  property p_gate;
    @(posedge clk_sys) disable iff (rst)
      !$past(gate_in_reg || gate_direct || interrupt_acknowledge) |-> bus_data_oe == 16'h0000;
  endproperty
  a_gate: assert property (p_gate) else $error("bus driven without gate");

  property p_direct;
    @(posedge clk_sys) disable iff (rst)
      (gate_direct && !gate_in_reg && !interrupt_acknowledge) |=>
        bus_data_out == $past(direct_data);
  endproperty
  a_direct: assert property (p_direct) else $error("direct data wrong");

  property p_left;
    @(posedge clk_sys) disable iff (rst)
      (in_ctl.op == iobdp_pkg::IOBDP_LEFT) |=>
        in_word[14:0] == $past(in_word[15:1]) && in_word[15] == $past(in_ctl.ser_in);
  endproperty
  a_left: assert property (p_left) else $error("left shift wrong");

  property p_right;
    @(posedge clk_sys) disable iff (rst)
      (out_ctl.op == iobdp_pkg::IOBDP_RIGHT && !out_load_from_bus) |=>
        out_word[15:1] == $past(out_word[14:0]);
  endproperty
  a_right: assert property (p_right) else $error("right shift wrong");

  property p_load;
    @(posedge clk_sys) disable iff (rst)
      (in_ctl.op == iobdp_pkg::IOBDP_LOAD) |=> in_word == $past(in_ctl.par_in);
  endproperty
  a_load: assert property (p_load) else $error("parallel load wrong");

  property p_hold;
    @(posedge clk_sys) disable iff (rst)
      (out_ctl.op == iobdp_pkg::IOBDP_HOLD && !out_load_from_bus) |=> $stable(out_word);
  endproperty
  a_hold: assert property (p_hold) else $error("output word changed");

  property p_rst_clear;
    @(posedge clk_sys) rst |=>
      in_word == iobdp_pkg::WORD_RST && out_word == iobdp_pkg::WORD_RST &&
      bus_data_oe == iobdp_pkg::BUS_IDLE;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset state wrong");

  property p_in_hold;
    @(posedge clk_sys) disable iff (rst)
      (in_ctl.op == iobdp_pkg::IOBDP_HOLD) |=> $stable(in_word);
  endproperty
  a_in_hold: assert property (p_in_hold) else $error("input word changed");

  property p_in_right;
    @(posedge clk_sys) disable iff (rst)
      (in_ctl.op == iobdp_pkg::IOBDP_RIGHT) |=>
        in_word[15:1] == $past(in_word[14:0]) && in_word[0] == $past(in_ctl.ser_in);
  endproperty
  a_in_right: assert property (p_in_right) else $error("input right shift wrong");

  property p_out_left;
    @(posedge clk_sys) disable iff (rst)
      (out_ctl.op == iobdp_pkg::IOBDP_LEFT && !out_load_from_bus) |=>
        out_word[14:0] == $past(out_word[15:1]) && out_word[15] == $past(out_ctl.ser_in);
  endproperty
  a_out_left: assert property (p_out_left) else $error("output left shift wrong");

  property p_ser_out;
    @(posedge clk_sys) disable iff (rst)
      (in_ctl.op == iobdp_pkg::IOBDP_LEFT) |=> in_ser_out == $past(in_word[1]);
  endproperty
  a_ser_out: assert property (p_ser_out) else $error("serial out bit wrong");

  property p_out_load;
    @(posedge clk_sys) disable iff (rst)
      (out_ctl.op == iobdp_pkg::IOBDP_LOAD && !out_load_from_bus) |=>
        out_word == $past(out_ctl.par_in);
  endproperty
  a_out_load: assert property (p_out_load) else $error("output load wrong");

  property p_bus_load;
    @(posedge clk_sys) disable iff (rst)
      out_load_from_bus |=> out_word == $past(bus_data_in);
  endproperty
  a_bus_load: assert property (p_bus_load) else $error("bus word not taken");

  property p_gate_in;
    @(posedge clk_sys) disable iff (rst)
      (gate_in_reg && !(interrupt_acknowledge && int_priority_win)) |=>
        bus_data_oe == iobdp_pkg::OE_ALL && bus_data_out == in_word;
  endproperty
  a_gate_in: assert property (p_gate_in) else $error("input word not on bus");

  property p_no_sel;
    @(posedge clk_sys) disable iff (rst)
      (upper_select_bits != code_switch_array) |=>
        !primary_select && !secondary_select;
  endproperty
  a_no_sel: assert property (p_no_sel) else $error("select without match");

  property p_interrupt_acknowledge_lsb;
    @(posedge clk_sys) disable iff (rst)
      (interrupt_acknowledge && int_priority_win) |=>
        bus_data_out[0] == $past(code_lsb_jumper) && bus_data_out[15:6] == 10'h000;
  endproperty
  a_interrupt_acknowledge_lsb: assert property (p_interrupt_acknowledge_lsb) else $error("code low bit wrong");
endmodule

// ===== verilog/iobdp_pkg.sv
package iobdp_pkg;
  localparam int WORD_W = 16;
  localparam int SW_W   = 5;
  localparam int CODE_W = 6;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] BUS_IDLE = 16'h0000;
  localparam logic [15:0] OE_ALL   = 16'hFFFF;
  localparam logic [15:0] OE_CODE  = 16'h003F;

  typedef enum logic [1:0] {
    IOBDP_HOLD  = 2'b00,
    IOBDP_LOAD  = 2'b01,
    IOBDP_LEFT  = 2'b10,
    IOBDP_RIGHT = 2'b11
  } iobdp_op_e;

  typedef struct packed {
    iobdp_op_e   op;
    logic        ser_in;
    logic [15:0] par_in;
  } iobdp_ctl_s;
endpackage

// ===== tb/iobdp_bus_model.sv
`timescale 1ns/10ps
// Far-side bus controller: open-drain data lines with pull-up, may also pull lines low
module iobdp_bus_model (
  input  wire logic [15:0] bus_data_out,
  input  wire logic [15:0] bus_data_oe,
  input  wire logic [15:0] ctrl_drive_low,
  output logic      [15:0] bus_wire
);
  // Released lines float to the pull-up level
  assign bus_wire = ~ctrl_drive_low & (~bus_data_oe | bus_data_out);
endmodule

// ===== tb/iobdp_tb_top.sv
`timescale 1ns/10ps
module iobdp_tb_top;
  logic                  clk_sys = 1'b0;
  logic                  rst = 1'b1;
  logic [4:0]            code_switch_array, upper_select_bits;
  logic                  lowest_select_bit, interrupt_acknowledge, int_priority_win;
  logic                  code_lsb_jumper, gate_in_reg, gate_direct, out_load_from_bus;
  logic [15:0]           bus_data_in, bus_data_out, bus_data_oe, direct_data, ctrl_low;
  logic [15:0]           in_word, out_word, ein, eout, ebus, eoe, m, bm;
  logic                  in_ser_out, out_ser_out, primary_select, secondary_select, ep, es;
  logic [31:0]           r;
  iobdp_pkg::iobdp_ctl_s in_ctl, out_ctl;
  int                    num_errors = 0;
  int                    total_checks = 0;

  always #5 clk_sys = ~clk_sys;

  iobdp_top iobdp_top_i (.clk_sys, .rst, .code_switch_array, .upper_select_bits,
    .lowest_select_bit, .interrupt_acknowledge, .int_priority_win, .code_lsb_jumper,
    .bus_data_in, .bus_data_out, .bus_data_oe, .gate_in_reg, .gate_direct, .direct_data,
    .out_load_from_bus, .in_ctl, .out_ctl, .in_word, .out_word, .in_ser_out, .out_ser_out,
    .primary_select, .secondary_select);
  iobdp_bus_model iobdp_bus_model_i (.bus_data_out, .bus_data_oe, .ctrl_drive_low(ctrl_low),
    .bus_wire(bus_data_in));

  function automatic logic [15:0] nxt(logic [15:0] w, iobdp_pkg::iobdp_ctl_s c);
    case (c.op)
      iobdp_pkg::IOBDP_LOAD:  return c.par_in;
      iobdp_pkg::IOBDP_LEFT:  return {c.ser_in, w[15:1]};
      iobdp_pkg::IOBDP_RIGHT: return {w[14:0], c.ser_in};
      default:                return w;
    endcase
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Random inputs with a scripted load then sixteen left shifts first
  task automatic drive(input int i);
    r = $urandom;
    {lowest_select_bit, interrupt_acknowledge, int_priority_win, code_lsb_jumper,
     gate_in_reg, gate_direct, out_load_from_bus, code_switch_array} = r[11:0];
    upper_select_bits = r[12] ? code_switch_array : 5'($urandom);
    in_ctl = 19'($urandom);
    out_ctl = 19'($urandom);
    direct_data = 16'($urandom);
    ctrl_low = r[14:13] == 2'h0 ? 16'($urandom) : 16'h0000;
    if (i < 17) begin
      in_ctl.op = i == 0 ? iobdp_pkg::IOBDP_LOAD : iobdp_pkg::IOBDP_LEFT;
      gate_in_reg = i == 16;
      interrupt_acknowledge = 1'b0;
    end
    #1;
    ep = upper_select_bits == code_switch_array && !lowest_select_bit;
    es = upper_select_bits == code_switch_array && lowest_select_bit;
    ein = nxt(ein, in_ctl);
    eout = out_load_from_bus ? bus_data_in : nxt(eout, out_ctl);
    m = 16'hFFFF;
    bm = 16'hFFFF;
    eoe = 16'hFFFF;
    if (interrupt_acknowledge && int_priority_win) begin
      {m, bm, eoe} = {3{16'h003F}};
      ebus = {10'h000, code_switch_array, code_lsb_jumper};
    end else if (gate_in_reg) begin
      ebus = ein;
    end else if (gate_direct) begin
      ebus = direct_data;
    end else begin
      {bm, eoe} = 32'h0000_0000;
    end
  endtask

  initial begin
    {code_switch_array, upper_select_bits, lowest_select_bit, interrupt_acknowledge} = '0;
    {int_priority_win, code_lsb_jumper, gate_in_reg, gate_direct, out_load_from_bus} = '0;
    {direct_data, ctrl_low, in_ctl, out_ctl, ein, eout} = '0;
    void'($urandom(32'hDE8A));
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    chk(in_word | out_word | bus_data_oe, 16'h0000);
    $display("Test reset done");
    for (int i = 0; i < 400; i++) begin
      drive(i);
      @(negedge clk_sys);
      chk(in_word, ein);
      chk(out_word, eout);
      chk({14'h0000, in_ser_out, out_ser_out}, {14'h0000, ein[0], eout[0]});
      chk({14'h0000, primary_select, secondary_select}, {14'h0000, ep, es});
      chk(bus_data_oe & m, eoe & m);
      chk(bus_data_out & bm, ebus & bm);
      if (i == 16) begin
        $display("Test serial fill done");
      end
    end
    $display("Test random done");
    end_of_test;
  end

  initial begin
    #20000;
    num_errors++;
    end_of_test;
  end
endmodule
